// File: bench/dscd_host.sv
/*
 * dscd_host: host serial port model driving the four command pins.
 * assumes: sys_clk from the bench; the link clock runs at 80 ns only inside frames.
 */
`timescale 1ns/1ps
module dscd_host (
	input  wire logic sys_clk,
	output logic      sclk_pin,
	output logic      din_pin,
	output logic      frame_sync_pin,
	output logic      cs_n_pin
);
	initial begin
		sclk_pin = 1'b0;
		din_pin = 1'b0;
		frame_sync_pin = 1'b1;
		cs_n_pin = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// sends w[n-1:0] msb first; abort lifts chip select first and raises frame sync 8 ticks later
	task automatic send(input logic [15:0] w, input int n, input bit abort);
		cs_n_pin <= 1'b0;
		tick(2);
		frame_sync_pin <= 1'b0;
		tick(4);
		for (int i = n - 1; i >= 0; i--) begin
			sclk_pin <= 1'b1;
			din_pin <= w[i];
			tick(4);
			sclk_pin <= 1'b0;
			tick(4);
		end
		// hold time over: the line no longer shows the last bit
		din_pin <= ~w[0];
		if (abort) begin
			cs_n_pin <= 1'b1;
			tick(8);
			frame_sync_pin <= 1'b1;
		end else begin
			if (n == 16) begin
				sclk_pin <= 1'b1;
				tick(4);
				sclk_pin <= 1'b0;
				tick(4);
			end
			frame_sync_pin <= 1'b1;
			tick(8);
			cs_n_pin <= 1'b1;
		end
		tick(8);
	endtask
endmodule // dscd_host

// File: bench/tb_top.sv
/*
 * tb_top: self-checking bench of dscd_top with the host model on its pins.
 * assumes: clk_en only drops while the link is idle, since a frozen sync chain
 * would miss pin edges.
 */
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk, rst, clk_en, apply_ready, rnd_ready, fix_ready;
	logic        sclk_pin, din_pin, frame_sync_pin, cs_n_pin;
	logic [7:0]  dac_code, e_code;
	logic [1:0]  vref_sel, e_vref;
	logic        speed_fast, power_down, vref_external, vref_int_1v024, vref_int_2v048;
	logic        update_pulse, reserved_pulse, word_waiting;
	logic [15:0] q[$];
	logic [31:0] seed;
	logic [31:0] rseed = 32'h0000_354e;
	int          n_errors, checks_done;

	dscd_top dscd_top_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.sclk_pin(sclk_pin), .din_pin(din_pin), .frame_sync_pin(frame_sync_pin),
		.cs_n_pin(cs_n_pin), .apply_ready(apply_ready), .dac_code(dac_code),
		.speed_fast(speed_fast), .power_down(power_down), .vref_sel(vref_sel),
		.vref_external(vref_external), .vref_int_1v024(vref_int_1v024),
		.vref_int_2v048(vref_int_2v048), .update_pulse(update_pulse),
		.reserved_pulse(reserved_pulse), .word_waiting(word_waiting));
	dscd_host dscd_host_inst (.sys_clk(sys_clk), .sclk_pin(sclk_pin), .din_pin(din_pin),
		.frame_sync_pin(frame_sync_pin), .cs_n_pin(cs_n_pin));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// note layout {ext, 1v024, 2v048, reserved, power, speed, vref, code}
	task automatic send(input logic [15:0] w, input int n, input bit abort);
		logic [1:0] tg;
		w = w & (16'hffff >> (16 - n));
		tg = {w[15], w[12]};
		// an aborted frame of fewer than 16 bits never reaches the latches, so it must not move the model
		if (!abort && tg == 2'b00) e_code = w[11:4];
		if (!abort && tg == 2'b11) e_vref = w[1:0];
		if (!abort) q.push_back({e_vref == 2'b00 || e_vref == 2'b11, e_vref == 2'b01,
			e_vref == 2'b10, tg[1] ^ tg[0], w[13], w[14], e_vref, e_code});
		dscd_host_inst.send(w, n, abort);
	endtask

	task automatic drain(input string name);
		int k;
		k = 0;
		while (q.size() != 0 && k < 20000) begin
			@(posedge sys_clk);
			k++;
		end
		check("pending updates", 16'(q.size()), 16'h0);
		$display("test %s done", name);
	endtask

	// outputs are registers, so values at the pulse edge are settled
	always @(posedge sys_clk) begin
		if (update_pulse === 1'b1) begin
			if (q.size() == 0) check("unexpected update", 16'h1, 16'h0);
			else begin
				check("dac_code", dac_code, q[0][7:0]);
				check("vref_sel", vref_sel, q[0][9:8]);
				check("speed_fast", speed_fast, q[0][10]);
				check("power_down", power_down, q[0][11]);
				check("reserved_pulse", reserved_pulse, q[0][12]);
				check("vref_flags", {vref_external, vref_int_1v024, vref_int_2v048},
					q[0][15:13]);
				void'(q.pop_front());
			end
		end
	end

	// receiver stalls about a quarter of the cycles during random traffic
	always @(posedge sys_clk) begin
		rseed = xs(rseed);
		apply_ready <= rnd_ready ? (rseed[0] | rseed[1]) : fix_ready;
	end

	initial begin
		#500_000;
		n_errors++;
		close_out;
	end

	initial begin
		logic [15:0] w;
		seed = 32'h0000_354e;
		rst = 1'b1;
		clk_en = 1'b1;
		fix_ready = 1'b1;
		rnd_ready = 1'b0;
		e_code = 8'h00;
		e_vref = 2'h0;
		n_errors = 0;
		checks_done = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (8) @(posedge sys_clk);
		check("reset code", dac_code, 8'h00);
		check("reset vref", vref_sel, 2'h0);
		check("reset flags", {speed_fast, power_down, word_waiting, vref_external}, 4'h1);
		$display("test reset done");
		send(16'hd002, 16, 0);
		send(16'h4ab0, 16, 0);
		for (int r = 0; r < 4; r++) send(16'hbffc | 16'(r), 16, 0);
		send(16'h5120, 16, 0);
		send(16'h8340, 16, 0);
		drain("directed");
		send(16'h00a5, 8, 0);
		send(16'h7fff, 7, 1);
		drain("frames");
		fix_ready <= 1'b0;
		send(16'h0120, 16, 0);
		send(16'h0340, 16, 0);
		check("word_waiting", word_waiting, 1'b1);
		send(16'h0560, 16, 0);
		check("held words", 16'(q.size()), 16'h3);
		// a frozen block must not apply a waiting word even with the receiver ready
		clk_en <= 1'b0;
		fix_ready <= 1'b1;
		repeat (12) @(posedge sys_clk);
		check("frozen words", 16'(q.size()), 16'h3);
		clk_en <= 1'b1;
		drain("buffer");
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		e_code = 8'h00;
		e_vref = 2'h0;
		repeat (4) @(posedge sys_clk);
		check("mid reset code", dac_code, 8'h00);
		check("mid reset vref", vref_sel, 2'h0);
		$display("test mid reset done");
		rnd_ready <= 1'b1;
		for (int i = 0; i < 30; i++) begin
			seed = xs(seed);
			w = seed[15:0];
			if ({w[15], w[12]} == 2'b00) w[3:0] = 4'h0;
			send(w, 16, 0);
		end
		rnd_ready <= 1'b0;
		fix_ready <= 1'b1;
		drain("random");
		close_out;
	end
endmodule // tb_top

// File: rtl/dscd_buf.sv
/*
 * dscd_buf: small ring buffer with valid/ready on both sides.
 * assumes: producer and consumer on sys_clk; clk_en low freezes it.
 */
`timescale 1ns/1ps
module dscd_buf import dscd_pkg::*; #(
	parameter int WIDTH = WORD_BITS,
	parameter int DEPTH = BUF_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// refused at elaboration: the pointers wrap by plain overflow
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_params
		$error("dscd_buf: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_reg  [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0]    wptr_reg, wptr_next;
	logic [PW-1:0]    rptr_reg, rptr_next;
	logic [PW:0]      cnt_reg,  cnt_next;
	logic             push, pop;

	assign in_ready  = (cnt_reg != (PW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rptr_reg];

	always_comb begin
		push      = in_valid & in_ready & clk_en;
		pop       = out_valid & out_ready & clk_en;
		mem_next  = mem_reg;
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		cnt_next  = cnt_reg;
		if (push) begin
			mem_next[wptr_reg] = in_data;
			wptr_next          = wptr_reg + 1'b1;
		end
		if (pop)
			rptr_next = rptr_reg + 1'b1;
		if (push && !pop)
			cnt_next = cnt_reg + 1'b1;
		else if (pop && !push)
			cnt_next = cnt_reg - 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++)
				mem_reg[i] <= '0;
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg  <= '0;
		end else begin
			mem_reg  <= mem_next;
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg  <= cnt_next;
		end
	end

endmodule // dscd_buf

// File: rtl/dscd_pkg.sv
/*
 * dscd_pkg: constants, state codes and decode helpers shared by the
 * serial command decoder and its word buffer.
 * assumes: one system clock domain; pins are synchronised by the user module.
 */
package dscd_pkg;

	localparam int WORD_BITS = 16;
	localparam int CNT_W     = 4;

	// field positions inside the command word
	localparam int TGT_HI_BIT = 15;
	localparam int SPEED_BIT  = 14;
	localparam int PWR_BIT    = 13;
	localparam int TGT_LO_BIT = 12;
	localparam int CODE_MSB   = 11;
	localparam int CODE_LSB   = 4;
	localparam int VREF_HI    = 1;
	localparam int VREF_LO    = 0;

	localparam logic [CNT_W-1:0] LAST_BIT_CNT = 4'hf;
	localparam logic [CNT_W-1:0] FIRST_CNT    = 4'h0;

	// target select codes {high, low}
	localparam logic [1:0] TGT_OUTPUT_CODE = 2'h0;
	localparam logic [1:0] TGT_CONTROL     = 2'h3;

	// reference field codes
	localparam logic [1:0] VREF_EXT_A    = 2'h0;
	localparam logic [1:0] VREF_INT_1V024 = 2'h1;
	localparam logic [1:0] VREF_INT_2V048 = 2'h2;
	localparam logic [1:0] VREF_EXT_B    = 2'h3;

	// values after reset
	localparam logic [7:0]  RST_CODE = 8'h00;
	localparam logic [1:0]  RST_VREF = 2'h0;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// pin vector layout and idle levels {cs_n, frame_sync, din, sclk}
	localparam int         PIN_SCLK = 0;
	localparam int         PIN_DIN  = 1;
	localparam int         PIN_FS   = 2;
	localparam int         PIN_CS_N = 3;
	localparam logic [3:0] PIN_IDLE = 4'hc;

	localparam int BUF_DEPTH = 2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_HOLD  = 3'b100
	} dscd_state_e;

	function automatic logic [1:0] word_target(input logic [15:0] w);
		return {w[TGT_HI_BIT], w[TGT_LO_BIT]};
	endfunction

	function automatic logic vref_is_external(input logic [1:0] r);
		return (r == VREF_EXT_A) || (r == VREF_EXT_B);
	endfunction

endpackage

// File: rtl/dscd_top.sv
/*
 * dscd_top: serial command decoder of an 8-bit voltage-output converter.
 * Samples the four serial pins, assembles 16-bit command words, buffers
 * them and applies them to the output code, speed, power and reference
 * settings.
 * assumes: pins are asynchronous to sys_clk and the serial clock is at
 * most about a quarter of sys_clk; the analog side accepts settings via
 * apply_ready.
 */
`timescale 1ns/1ps
module dscd_top import dscd_pkg::*; (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic       sclk_pin,
	input  wire logic       din_pin,
	input  wire logic       frame_sync_pin,
	input  wire logic       cs_n_pin,
	input  wire logic       apply_ready,
	output logic      [7:0] dac_code,
	output logic            speed_fast,
	output logic            power_down,
	output logic      [1:0] vref_sel,
	output logic            vref_external,
	output logic            vref_int_1v024,
	output logic            vref_int_2v048,
	output logic            update_pulse,
	output logic            reserved_pulse,
	output logic            word_waiting
);

	// pin synchronisers: s1 feeds s2 only; a change counts when s2 and s3 agree
	logic [3:0] s1_reg, s1_next;
	logic [3:0] s2_reg, s2_next;
	logic [3:0] s3_reg, s3_next;
	logic [3:0] lvl_reg, lvl_next;
	logic [3:0] agree, pin_rise, pin_fall;

	always_comb begin
		s1_next  = {cs_n_pin, frame_sync_pin, din_pin, sclk_pin};
		s2_next  = s1_reg;
		s3_next  = s2_reg;
		agree    = ~(s2_reg ^ s3_reg);
		lvl_next = (agree & s3_reg) | (~agree & lvl_reg);
		pin_rise = agree & s3_reg & ~lvl_reg;
		pin_fall = agree & ~s3_reg & lvl_reg;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_reg  <= PIN_IDLE;
			s2_reg  <= PIN_IDLE;
			s3_reg  <= PIN_IDLE;
			lvl_reg <= PIN_IDLE;
		end else if (clk_en) begin
			s1_reg  <= s1_next;
			s2_reg  <= s2_next;
			s3_reg  <= s3_next;
			lvl_reg <= lvl_next;
		end
	end

	logic sclk_rise, sclk_fall, fs_rise, fs_fall, cs_low, din_bit;

	assign sclk_rise = pin_rise[PIN_SCLK];
	assign sclk_fall = pin_fall[PIN_SCLK];
	assign fs_rise   = pin_rise[PIN_FS];
	assign fs_fall   = pin_fall[PIN_FS];
	assign cs_low    = ~lvl_reg[PIN_CS_N];
	assign din_bit   = lvl_next[PIN_DIN];

	// word assembly
	dscd_state_e       state_reg, state_next;
	logic [CNT_W-1:0]  cnt_reg, cnt_next;
	logic [15:0]       shift_reg, shift_next;
	logic              fire_reg, fire_next;
	logic              push;
	logic              buf_in_ready;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		fire_next  = fire_reg;
		push       = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (fs_fall && cs_low) begin
					state_next = ST_SHIFT;
					cnt_next   = FIRST_CNT;
					shift_next = RST_WORD;
					fire_next  = 1'b0;
				end
			end
			ST_SHIFT: begin
				if (!cs_low) begin
					state_next = ST_IDLE;
				end else if (sclk_fall) begin
					shift_next = {shift_reg[14:0], din_bit};
					cnt_next   = cnt_reg + 1'b1;
					if (cnt_reg == LAST_BIT_CNT)
						state_next = ST_HOLD;
				end else if (fs_rise) begin
					// early end of frame: move what has arrived
					state_next = (cnt_reg == FIRST_CNT) ? ST_IDLE : ST_HOLD;
					fire_next  = 1'b1;
				end
			end
			ST_HOLD: begin
				// a deselect also releases the word so that it is never lost
				if (fire_reg || sclk_rise || fs_rise || !cs_low) begin
					fire_next = 1'b1;
					if (buf_in_ready) begin
						push       = 1'b1;
						state_next = ST_IDLE;
						fire_next  = 1'b0;
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
				fire_next  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= FIRST_CNT;
			shift_reg <= RST_WORD;
			fire_reg  <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			shift_reg <= shift_next;
			fire_reg  <= fire_next;
		end
	end

	// two words of slack: a stalled analog side holds the shifter in hold
	logic        buf_out_valid;
	logic [15:0] buf_out_data;

	dscd_buf #(
		.WIDTH (WORD_BITS),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.in_valid  (push),
		.in_ready  (buf_in_ready),
		.in_data   (shift_reg),
		.out_valid (buf_out_valid),
		.out_ready (apply_ready),
		.out_data  (buf_out_data)
	);

	// setting latches
	logic        apply;
	logic [1:0]  target;
	logic [7:0]  code_reg, code_next;
	logic [1:0]  vref_reg, vref_next;
	logic        speed_reg, speed_next;
	logic        pwr_reg, pwr_next;
	logic        ext_reg, ext_next;
	logic        i1_reg, i1_next;
	logic        i2_reg, i2_next;
	logic        upd_reg, upd_next;
	logic        rsv_reg, rsv_next;

	assign apply  = buf_out_valid & apply_ready & clk_en;
	assign target = word_target(buf_out_data);

	always_comb begin
		code_next  = code_reg;
		vref_next  = vref_reg;
		speed_next = speed_reg;
		pwr_next   = pwr_reg;
		upd_next   = 1'b0;
		rsv_next   = 1'b0;
		if (apply) begin
			speed_next = buf_out_data[SPEED_BIT];
			pwr_next   = buf_out_data[PWR_BIT];
			upd_next   = 1'b1;
			unique case (target)
				TGT_OUTPUT_CODE: code_next = buf_out_data[CODE_MSB:CODE_LSB];
				TGT_CONTROL:     vref_next = buf_out_data[VREF_HI:VREF_LO];
				default:         rsv_next  = 1'b1;
			endcase
		end
		ext_next = vref_is_external(vref_next);
		i1_next  = (vref_next == VREF_INT_1V024);
		i2_next  = (vref_next == VREF_INT_2V048);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			code_reg  <= RST_CODE;
			vref_reg  <= RST_VREF;
			speed_reg <= 1'b0;
			pwr_reg   <= 1'b0;
			ext_reg   <= 1'b1;
			i1_reg    <= 1'b0;
			i2_reg    <= 1'b0;
			upd_reg   <= 1'b0;
			rsv_reg   <= 1'b0;
		end else if (clk_en) begin
			code_reg  <= code_next;
			vref_reg  <= vref_next;
			speed_reg <= speed_next;
			pwr_reg   <= pwr_next;
			ext_reg   <= ext_next;
			i1_reg    <= i1_next;
			i2_reg    <= i2_next;
			upd_reg   <= upd_next;
			rsv_reg   <= rsv_next;
		end
	end

	assign dac_code       = code_reg;
	assign speed_fast     = speed_reg;
	assign power_down     = pwr_reg;
	assign vref_sel       = vref_reg;
	assign vref_external  = ext_reg;
	assign vref_int_1v024 = i1_reg;
	assign vref_int_2v048 = i2_reg;
	assign update_pulse   = upd_reg;
	assign reserved_pulse = rsv_reg;
	assign word_waiting   = buf_out_valid;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_start_on_fs: assert property (
		(state_reg == ST_IDLE) && fs_fall && cs_low && clk_en
		|=> (state_reg == ST_SHIFT) && (cnt_reg == FIRST_CNT))
		else $error("frame sync fall did not start a word");

	a_shift_msb_first: assert property (
		(state_reg == ST_SHIFT) && cs_low && sclk_fall && clk_en
		|=> (shift_reg == {$past(shift_reg[14:0]), $past(din_bit)}))
		else $error("serial bit not shifted in at the low end");

	a_sixteen_bits: assert property (
		(state_reg == ST_SHIFT) && $changed(state_reg) == 1'b0 ##0
		(state_reg == ST_SHIFT) && cs_low && sclk_fall && clk_en
		&& (cnt_reg == LAST_BIT_CNT) |=> (state_reg == ST_HOLD))
		else $error("sixteenth bit did not close the word");

	a_release_on_rise: assert property (
		(state_reg == ST_HOLD) && sclk_rise && buf_in_ready && clk_en
		|-> push ##1 (state_reg == ST_IDLE))
		else $error("word not released on serial clock rise");

	a_code_load: assert property (
		apply && (target == TGT_OUTPUT_CODE)
		|=> (dac_code == $past(buf_out_data[CODE_MSB:CODE_LSB])) && $stable(vref_sel))
		else $error("output code word loaded wrong value");

	a_ctrl_load: assert property (
		apply && (target == TGT_CONTROL)
		|=> (vref_sel == $past(buf_out_data[VREF_HI:VREF_LO])) && $stable(dac_code))
		else $error("control word loaded wrong reference");

	a_reserved_hold: assert property (
		apply && (target != TGT_OUTPUT_CODE) && (target != TGT_CONTROL)
		|=> $stable(dac_code) && $stable(vref_sel) && reserved_pulse)
		else $error("reserved word changed a latch");

	a_mode_bits_every: assert property (
		apply |=> (speed_fast == $past(buf_out_data[SPEED_BIT]))
		&& (power_down == $past(buf_out_data[PWR_BIT])) && update_pulse)
		else $error("speed or power bit not taken from word");

	a_vref_decode: assert property (
		(vref_external == ((vref_sel == VREF_EXT_A) || (vref_sel == VREF_EXT_B)))
		&& (vref_int_2v048 == (vref_sel == VREF_INT_2V048))
		&& (vref_int_1v024 == (vref_sel == VREF_INT_1V024)))
		else $error("reference decode mismatch");

	a_reset_clear: assert property (disable iff (1'b0)
		rst |=> (dac_code == RST_CODE) && (vref_sel == RST_VREF)
		&& !speed_fast && !power_down && (state_reg == ST_IDLE))
		else $error("reset did not clear the latches");

	c_code_word:   cover property (apply && (target == TGT_OUTPUT_CODE));
	c_ctrl_word:   cover property (apply && (target == TGT_CONTROL));
	c_short_frame: cover property ((state_reg == ST_SHIFT) && fs_rise && cs_low
		&& (cnt_reg != FIRST_CNT) && clk_en);
	c_buffer_full: cover property ((state_reg == ST_HOLD) && fire_reg && !buf_in_ready);

endmodule // dscd_top
